// *** src/dmps_sequencer.sv ***
// Device-mode decoder and power-up sequencer with an AHB-Lite register port.
// Assumes synchronous analog status inputs and one 100 MHz clock.
// Overview of operation
// - Mode decodes to synth for nonzero, receive for 10, transmit for 11
// - Leaving transmit mode drops the amplifier at once, no ramp
// - Entering transmit mode kills any receive path immediately
// - Mode set by register write, receive command loads 10, transmit 11
// - Software reset or powerdown force mode 00; the oscillator stops as well
// - Transmit command with held ninth edge prepares; amplifier on at edge
// - Leaving powerdown clears the indicator and starts the digital regulator
// - Oscillator or external buffer enabled per disable and buffer bits
// - After oscillator ready and settle count, reference valid opens gate, recal
// - Synth enable powers PLL and VCO regulators, waits for supply settled
// - Two cycles after settling, detector, prescaler, synth clock and lock detect are on
// - VCO calibration ends on lock; manual calibration stops transmit or receive
// - Transmit prep enables amplifier regulator and divider, ends without brown-out
// - Receive prep enables bandgap, divider, reference clock and analog section
// - Each receive entry runs filter calibration; prep ends when it finishes
// - Commands run only the stages not yet up, the whole sequence from powerdown; ready only after all stages settle
// - Flags gated by enable register; reading flag register clears it
// - Regulator disable bit forces digital regulator off, else on outside powerdown
// - In powerdown the digital regulator is bypassed to retain registers
// - Test override bits start regulators only, not the blocks they feed
// - Software reset acts as power-on reset except for the flag register; clears on select fall after write
// - Other bits written with the reset bit take their reset values
// - Powerdown bit set on power-on reset, software reset or watchdog expiry
// - Power-on reset sets a non-maskable power-on flag
`timescale 1ns/10ps
module dmps_sequencer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic osc_amplitude_ok,
  input wire logic lo_supply_settled,
  input wire logic lo_locked,
  input wire logic pa_brownout,
  input wire logic filter_cal_done,
  input wire logic watchdog_expired,
  input wire logic serial_select_line,
  output logic synth_enable,
  output logic receive_enable,
  output logic transmit_enable,
  output logic op_ready,
  output dmps_pkg::dmps_ana_t ana
);
  import dmps_pkg::*;

  logic acc;
  logic addr_ok;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic wr_pwr, wr_clk, wr_ien, wr_t1, wr_t2, wr_cmd;
  logic rd_ifl;
  logic [31:0] rd_mux;
  logic [1:0] mode_r;
  logic [1:0] mode_d_r;
  logic pd_r, srst_r, srst_arm_r, sel_d_r;
  logic osc_dis_r, ext_en_r, dreg_dis_r, tx_hold_r;
  logic [7:0] ien_r;
  logic [7:0] ifl_r;
  logic [7:0] ev;
  logic [2:0] t2_r;
  logic [3:0] ref_cnt_r;
  logic refv_r, clk_src_ok, force_pd, cal_cmd, mode_chg;
  logic syn, pfd, tx_path, rx_path;
  dmps_state_t state_r;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, OKAY always
  assign acc = hsel & htrans[1] & hready;
  assign addr_ok = (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'h0);
  assign rd_ifl = acc & ~hwrite & addr_ok & (haddr[7:0] == OFS_IFL);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend_r <= acc & hwrite & addr_ok;
      if (acc) begin
        wr_addr_r <= haddr[7:0];
      end
      if (acc & ~hwrite) begin
        hrdata <= addr_ok ? rd_mux : 32'h00000000;
      end
    end
  end

  assign wr_pwr = wr_pend_r & (wr_addr_r == OFS_PWR);
  assign wr_clk = wr_pend_r & (wr_addr_r == OFS_CLK);
  assign wr_ien = wr_pend_r & (wr_addr_r == OFS_IEN);
  assign wr_t1 = wr_pend_r & (wr_addr_r == OFS_T1);
  assign wr_t2 = wr_pend_r & (wr_addr_r == OFS_T2);
  assign wr_cmd = wr_pend_r & (wr_addr_r == OFS_CMD);
  assign cal_cmd = wr_cmd & hwdata[CMD_VCOCAL_BIT];

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (haddr[7:0])
      OFS_PWR: rd_mux[3:0] = {srst_r, pd_r, mode_r};
      OFS_CLK: rd_mux[1:0] = {ext_en_r, osc_dis_r};
      OFS_IEN: rd_mux[7:0] = ien_r;
      OFS_IFL: rd_mux[7:0] = ifl_r;
      OFS_T1: rd_mux[T1_DREG_DIS_BIT] = dreg_dis_r;
      OFS_T2: rd_mux[2:0] = t2_r;
      OFS_CMD: rd_mux[CMD_HOLD_BIT] = tx_hold_r;
      OFS_STAT: rd_mux = {14'h0000, op_ready, refv_r, 6'h00, state_r};
      default: rd_mux = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software reset: hold mode, powerdown and configuration registers at reset until select falls
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      srst_r <= 1'b0;
      srst_arm_r <= 1'b0;
      sel_d_r <= 1'b0;
    end else begin
      sel_d_r <= serial_select_line;
      if (wr_pwr & hwdata[PWR_RST_BIT]) begin
        srst_r <= 1'b1;
        srst_arm_r <= 1'b1;
      end else if (srst_arm_r & sel_d_r & ~serial_select_line) begin
        srst_r <= 1'b0;
        srst_arm_r <= 1'b0;
      end
    end
  end

  assign force_pd = pd_r | srst_r;

  // Device mode and powerdown bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_r <= MODE_OFF;
      pd_r <= PWR_PD_RESET;
    end else if (srst_r | (wr_pwr & hwdata[PWR_RST_BIT]) | watchdog_expired) begin
      // written bits replaced by reset values
      mode_r <= MODE_OFF;
      pd_r <= PWR_PD_RESET;
    end else if (wr_pwr) begin
      pd_r <= hwdata[PWR_PD_BIT];
      mode_r <= hwdata[PWR_PD_BIT] ? MODE_OFF : hwdata[PWR_MODE_LSB +: 2];
    end else if (wr_cmd) begin
      if (cal_cmd & mode_r[1]) begin
        mode_r <= MODE_SYN;
      end else if (hwdata[CMD_TX_BIT]) begin
        mode_r <= MODE_TX;
        pd_r <= 1'b0;
      end else if (hwdata[CMD_RX_BIT]) begin
        mode_r <= MODE_RX;
        pd_r <= 1'b0;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys) begin
    if (rst | srst_r) begin
      osc_dis_r <= 1'b0;
      ext_en_r <= 1'b0;
      ien_r <= IEN_RESET;
      dreg_dis_r <= 1'b0;
      t2_r <= 3'h0;
    end else begin
      if (wr_clk) begin
        osc_dis_r <= hwdata[CLK_OSC_DISABLE_BIT];
        ext_en_r <= hwdata[CLK_EXTBUF_BIT];
      end
      if (wr_ien) begin
        ien_r <= hwdata[7:0];
      end
      if (wr_t1) begin
        dreg_dis_r <= hwdata[T1_DREG_DIS_BIT];
      end
      if (wr_t2) begin
        t2_r <= hwdata[2:0];
      end
    end
  end

  // Held ninth edge of a transmit command
  // A transmit command also wakes from powerdown, so it must win over force_pd from pd_r, but not over srst_r
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_hold_r <= 1'b0;
    end else if (wr_cmd & hwdata[CMD_TX_BIT] & ~cal_cmd & ~srst_r) begin
      tx_hold_r <= hwdata[CMD_HOLD_BIT];
    end else if (force_pd | (wr_cmd & hwdata[CMD_NINTH_BIT]) | (mode_r != MODE_TX)) begin
      tx_hold_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference clock validation counter
  assign clk_src_ok = osc_dis_r ? ext_en_r : osc_amplitude_ok;

  always_ff @(posedge clk_sys) begin
    if (rst | force_pd | ~clk_src_ok | (state_r == ST_DIGREG)) begin
      ref_cnt_r <= 4'h0;
      refv_r <= 1'b0;
    end else if (ref_cnt_r != REF_SETTLE_CYC) begin
      ref_cnt_r <= ref_cnt_r + 4'h1;
    end else begin
      refv_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  assign mode_chg = mode_r != mode_d_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_d_r <= MODE_OFF;
    end else begin
      mode_d_r <= mode_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst | force_pd) begin
      state_r <= ST_PD;
    end else if (~refv_r & |(state_r & (SYN_STAGES | ST_IDLE))) begin
      state_r <= ST_XTAL;
    end else if ((mode_r == MODE_OFF) & |(state_r & SYN_STAGES)) begin
      state_r <= ST_IDLE;
    end else if (cal_cmd & |(state_r & PFD_STAGES)) begin
      state_r <= ST_VCOCAL;
    end else begin
      unique case (state_r)
        ST_PD: state_r <= ST_DIGREG;
        ST_DIGREG: if (~dreg_dis_r) begin
          state_r <= ST_XTAL;
        end
        ST_XTAL: if (refv_r) begin
          state_r <= ST_IDLE;
        end
        ST_IDLE: state_r <= ST_SYNREG;
        ST_SYNREG: if (lo_supply_settled) begin
          state_r <= ST_PFD;
        end
        ST_PFD: state_r <= ST_VCOCAL;
        ST_VCOCAL: if (lo_locked) begin
          state_r <= (mode_r == MODE_TX) ? ST_TXPREP :
                     (mode_r == MODE_RX) ? ST_RXPREP : ST_ACTIVE;
        end
        ST_TXPREP: if (mode_chg) begin
          state_r <= (mode_r == MODE_RX) ? ST_RXPREP : ST_ACTIVE;
        end else if (ana.amplifier_regulator_on & ~pa_brownout) begin
          state_r <= ST_ACTIVE;
        end
        ST_RXPREP: if (mode_chg) begin
          state_r <= (mode_r == MODE_TX) ? ST_TXPREP : ST_ACTIVE;
        end else if (filter_cal_done) begin
          state_r <= ST_ACTIVE;
        end
        ST_ACTIVE: if (mode_chg) begin
          state_r <= (mode_r == MODE_TX) ? ST_TXPREP :
                     (mode_r == MODE_RX) ? ST_RXPREP : ST_ACTIVE;
        end
        default: state_r <= ST_PD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered enables
  assign syn = |(state_r & SYN_STAGES);
  assign pfd = |(state_r & PFD_STAGES);
  assign tx_path = |(state_r & (ST_TXPREP | ST_ACTIVE)) & (mode_r == MODE_TX);
  assign rx_path = |(state_r & (ST_RXPREP | ST_ACTIVE)) & (mode_r == MODE_RX);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      synth_enable <= 1'b0;
      receive_enable <= 1'b0;
      transmit_enable <= 1'b0;
      op_ready <= 1'b0;
    end else begin
      synth_enable <= mode_r != MODE_OFF;
      receive_enable <= mode_r == MODE_RX;
      transmit_enable <= mode_r == MODE_TX;
      op_ready <= (state_r == ST_ACTIVE) & ~tx_hold_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ana <= '0;
      ana.dig_reg_bypass <= 1'b1;
    end else begin
      ana.dig_reg_on <= ~force_pd & ~dreg_dis_r;
      ana.dig_reg_bypass <= force_pd;
      ana.xo_enable <= ~force_pd & ~osc_dis_r;
      ana.ext_buf_enable <= ~force_pd & osc_dis_r & ext_en_r;
      ana.ref_clock_valid <= refv_r;
      ana.master_clk_gate <= refv_r;
      ana.poll_recal <= refv_r & ~ana.ref_clock_valid;
      ana.pll_reg_on <= syn | t2_r[T2_PLL_BIT];
      ana.vco_regulator_on <= syn | t2_r[T2_VCO_BIT];
      ana.phase_detector_on <= pfd;
      ana.prescaler_on <= pfd;
      ana.synth_clk_on <= pfd;
      ana.lock_detect_on <= pfd;
      ana.vco_cal_on <= state_r == ST_VCOCAL;
      ana.amplifier_regulator_on <= tx_path | t2_r[T2_PA_BIT];
      ana.tx_divider_on <= tx_path;
      ana.pa_on <= tx_path & (state_r == ST_ACTIVE) & ~tx_hold_r;
      ana.rx_bandgap_on <= rx_path;
      ana.rx_divider_on <= rx_path;
      ana.rx_ref_clock_on <= rx_path;
      ana.rx_analog_on <= rx_path;
      ana.filter_cal_on <= state_r == ST_RXPREP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags, set wins over read clear
  assign ev = {1'b0,
               (state_r == ST_TXPREP) & ana.amplifier_regulator_on & pa_brownout,
               watchdog_expired,
               (state_r == ST_RXPREP) & filter_cal_done & ~mode_chg,
               (state_r == ST_TXPREP) & ana.amplifier_regulator_on & ~pa_brownout,
               (state_r == ST_VCOCAL) & lo_locked,
               refv_r & ~ana.ref_clock_valid,
               1'b0};

  for (genvar i = 0; i < 8; i++) begin : g_flag
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        ifl_r[i] <= IFL_RESET[i];
      end else begin
        ifl_r[i] <= (ifl_r[i] & ~rd_ifl) | (ev[i] & (ien_r[i] | IFL_NMI_MASK[i]));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_settled;
    state_r == ST_SYNREG && lo_supply_settled && !force_pd && refv_r && mode_r != MODE_OFF;
  endsequence

  sequence s_locked;
    state_r == ST_VCOCAL && lo_locked && !force_pd && refv_r && mode_r != MODE_OFF && !cal_cmd;
  endsequence

  AST_DECODE: assert property (receive_enable |-> synth_enable && !transmit_enable)
    else $error("receive enable without synth or with transmit");
  AST_TX_ABORT: assert property ($fell(transmit_enable) |-> !ana.pa_on)
    else $error("amplifier still on after leaving transmit");
  AST_RX_ABORT: assert property (transmit_enable |-> !ana.rx_analog_on)
    else $error("receive analog on in transmit mode");
  AST_PD_MODE: assert property (pd_r |-> mode_r == MODE_OFF ##1 !synth_enable)
    else $error("mode not 00 in powerdown");
  AST_HOLD: assert property (tx_hold_r |=> !ana.pa_on)
    else $error("amplifier on before ninth edge");
  AST_REF: assert property ($rose(ana.ref_clock_valid) |-> ana.master_clk_gate && ana.poll_recal)
    else $error("gate or recal missing at reference valid");
  AST_PFD: assert property (s_settled |-> ##2 ana.phase_detector_on && ana.prescaler_on)
    else $error("detector not on two cycles after settle");
  AST_LOCK: assert property (s_locked |=> state_r != ST_VCOCAL)
    else $error("calibration did not end on lock");
  AST_RDCLR: assert property (rd_ifl && ev == 8'h00 |=> ifl_r == 8'h00)
    else $error("flag register not cleared by read");
  AST_DREG: assert property (dreg_dis_r |=> !ana.dig_reg_on)
    else $error("digital regulator on while disabled");
  AST_SRST: assert property (wr_pwr && hwdata[PWR_RST_BIT] |=> srst_r && pd_r && mode_r == MODE_OFF)
    else $error("reset write did not force reset values");

endmodule

// *** src/dmps_pkg.sv ***
// Package for the device-mode power sequencer: register map, field positions,
// reset values, timing counts, sequencer states and the analog enable bundle.
// Assumes a 32-bit AHB-Lite register port and a 100 MHz system clock.
package dmps_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_PWR = 8'h00;
  localparam logic [7:0] OFS_CLK = 8'h04;
  localparam logic [7:0] OFS_IEN = 8'h08;
  localparam logic [7:0] OFS_IFL = 8'h0C;
  localparam logic [7:0] OFS_T1 = 8'h10;
  localparam logic [7:0] OFS_T2 = 8'h14;
  localparam logic [7:0] OFS_CMD = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;

  // power_mode_register fields
  localparam int PWR_MODE_LSB = 0;
  localparam int PWR_PD_BIT = 2;
  localparam int PWR_RST_BIT = 3;
  localparam logic PWR_PD_RESET = 1'b1;

  // clock_connect_register fields
  localparam int CLK_OSC_DISABLE_BIT = 0;
  localparam int CLK_EXTBUF_BIT = 1;

  // Interrupt flag bits
  localparam int IFL_POR = 0;
  localparam int IFL_REF = 1;
  localparam int IFL_LOCK = 2;
  localparam int IFL_TXRDY = 3;
  localparam int IFL_RXRDY = 4;
  localparam int IFL_WDOG = 5;
  localparam int IFL_BROWN = 6;
  localparam logic [7:0] IFL_RESET = 8'h01;
  localparam logic [7:0] IFL_NMI_MASK = 8'h01;
  localparam logic [7:0] IEN_RESET = 8'h00;

  // Test register fields
  localparam int T1_DREG_DIS_BIT = 0;
  localparam int T2_PLL_BIT = 0;
  localparam int T2_VCO_BIT = 1;
  localparam int T2_PA_BIT = 2;

  // Command register bits (self clearing except hold, which also reads back)
  localparam int CMD_RX_BIT = 0;
  localparam int CMD_TX_BIT = 1;
  localparam int CMD_HOLD_BIT = 2;
  localparam int CMD_NINTH_BIT = 3;
  localparam int CMD_VCOCAL_BIT = 4;

  // Status register fields
  localparam int STAT_REFV_BIT = 16;
  localparam int STAT_READY_BIT = 17;

  // Device mode codes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SYN = 2'h1;
  localparam logic [1:0] MODE_RX = 2'h2;
  localparam logic [1:0] MODE_TX = 2'h3;

  // Reference clock settling: a few periods after the oscillator is good
  localparam int REF_SETTLE_NS = 80;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [3:0] REF_SETTLE_CYC = 4'((REF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [9:0] {
    ST_PD = 10'h001,
    ST_DIGREG = 10'h002,
    ST_XTAL = 10'h004,
    ST_IDLE = 10'h008,
    ST_SYNREG = 10'h010,
    ST_PFD = 10'h020,
    ST_VCOCAL = 10'h040,
    ST_TXPREP = 10'h080,
    ST_RXPREP = 10'h100,
    ST_ACTIVE = 10'h200
  } dmps_state_t;

  localparam logic [9:0] SYN_STAGES = 10'h3F0;
  localparam logic [9:0] PFD_STAGES = 10'h3E0;

  typedef struct packed {
    logic dig_reg_on;
    logic dig_reg_bypass;
    logic xo_enable;
    logic ext_buf_enable;
    logic ref_clock_valid;
    logic master_clk_gate;
    logic poll_recal;
    logic pll_reg_on;
    logic vco_regulator_on;
    logic phase_detector_on;
    logic prescaler_on;
    logic synth_clk_on;
    logic lock_detect_on;
    logic vco_cal_on;
    logic amplifier_regulator_on;
    logic tx_divider_on;
    logic pa_on;
    logic rx_bandgap_on;
    logic rx_divider_on;
    logic rx_ref_clock_on;
    logic rx_analog_on;
    logic filter_cal_on;
  } dmps_ana_t;

endpackage

// *** test/dmps_ana_model.sv ***
// Behavioural model of the analog side: oscillator, supplies, lock, filter, PA.
// Assumes the sequencer's registered enable bundle and one clock.
`timescale 1ns/10ps
module dmps_ana_model #(
  parameter int DLY = 5
) (
  input wire logic clk_sys,
  input wire logic rst,
  input dmps_pkg::dmps_ana_t ana,
  output logic osc_amplitude_ok,
  output logic lo_supply_settled,
  output logic lo_locked,
  output logic pa_brownout,
  output logic filter_cal_done
);
  import dmps_pkg::*;
  logic [7:0] c_xo, c_lo, c_lk, c_fc, c_pa;

  function automatic logic [7:0] inc(input logic en, input logic [7:0] c);
    return en ? ((c == 8'hFF) ? c : c + 8'h01) : 8'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Each status derives from a counter that runs with its enable and clears when it drops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      c_xo <= 8'h00;
      c_lo <= 8'h00;
      c_lk <= 8'h00;
      c_fc <= 8'h00;
      c_pa <= 8'h00;
    end else begin
      c_xo <= inc(ana.xo_enable | ana.ext_buf_enable, c_xo);
      c_lo <= inc(ana.pll_reg_on & ana.vco_regulator_on, c_lo);
      c_lk <= inc(ana.lock_detect_on, c_lk);
      c_fc <= inc(ana.filter_cal_on, c_fc);
      c_pa <= inc(ana.amplifier_regulator_on, c_pa);
    end
  end

  assign osc_amplitude_ok = (c_xo >= 8'(DLY));
  assign lo_supply_settled = (c_lo >= 8'(DLY));
  assign lo_locked = (c_lk >= 8'(2 * DLY));
  // Calibration end is a single pulse, not a level
  assign filter_cal_done = (c_fc == 8'(3 * DLY));
  // Regulator shows brown-out during its first cycles
  assign pa_brownout = ana.amplifier_regulator_on & (c_pa < 8'h03);
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the mode decoder and power-up sequencer.
// Assumes the analog model on the far side and AHB-Lite register access.
`timescale 1ns/10ps
module testbench;
  import dmps_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, watchdog_expired = 1'b0, serial_select_line = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, synth_enable, receive_enable, transmit_enable, op_ready;
  logic osc_amplitude_ok, lo_supply_settled, lo_locked, pa_brownout, filter_cal_done;
  logic [1:0] m;
  dmps_ana_t ana;
  int err_total = 0, check_count = 0, cyc = 0, seed = 21768, i;

  always #5 clk_sys = ~clk_sys;

  dmps_sequencer u_dmps_sequencer (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .osc_amplitude_ok,
    .lo_supply_settled, .lo_locked, .pa_brownout, .filter_cal_done, .watchdog_expired,
    .serial_select_line, .synth_enable, .receive_enable, .transmit_enable, .op_ready, .ana);
  dmps_ana_model u_dmps_ana_model (.clk_sys, .rst, .ana, .osc_amplitude_ok,
    .lo_supply_settled, .lo_locked, .pa_brownout, .filter_cal_done);

  task test_done;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      $display("[ERR] %0t run too long", $time);
      test_done;
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask

  task b(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask

  // Single AHB-Lite transfer; read data taken at the end of the data phase
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: return op_ready;
      1: return ana.ref_clock_valid;
      2: return ana.tx_divider_on;
      default: return ana.phase_detector_on;
    endcase
  endfunction

  task wt(input int w);
    int n;
    n = 0;
    // Let a level left over from the previous mode drop first
    repeat (3) @(posedge clk_sys);
    while (sig(w) !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    b(sig(w), 1'b1);
  endtask

  function automatic logic [2:0] dec(input logic [1:0] mm);
    return {mm == MODE_TX, mm == MODE_RX, mm != MODE_OFF};
  endfunction

  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    ahb(1'b0, 32'(OFS_PWR), 32'h0); chk(rd, 32'h4);
    ahb(1'b0, 32'(OFS_IFL), 32'h0); chk(rd, 32'h1);
    ahb(1'b0, 32'(OFS_IFL), 32'h0); chk(rd, 32'h0);
    b(ana.dig_reg_bypass, 1'b1);
    ahb(1'b1, 32'(OFS_T2), 32'h7);
    repeat (3) @(posedge clk_sys);
    chk({ana.pll_reg_on, ana.vco_regulator_on, ana.amplifier_regulator_on}, 32'h7);
    chk({ana.phase_detector_on, ana.tx_divider_on, synth_enable}, 32'h0);
    ahb(1'b1, 32'(OFS_T2), 32'h0);
    $display("reset and override test done");
    ahb(1'b1, 32'(OFS_PWR), 32'h1);
    wt(1);
    chk({ana.dig_reg_on, ana.xo_enable, ana.dig_reg_bypass}, 32'h6);
    wt(3);
    chk({lo_supply_settled, ana.prescaler_on, ana.lock_detect_on}, 32'h7);
    for (i = 0; i < 10; i++) begin
      m = (i < 4) ? 2'(i) : 2'($random(seed));
      ahb(1'b1, 32'(OFS_PWR), {30'h0, m});
      repeat (3) @(posedge clk_sys);
      chk({transmit_enable, receive_enable, synth_enable}, {29'h0, dec(m)});
    end
    $display("wake and decode test done");
    ahb(1'b1, 32'(OFS_CMD), 32'h2);
    wt(0);
    chk({transmit_enable, ana.pa_on, ana.amplifier_regulator_on}, 32'h7);
    ahb(1'b0, 32'(OFS_PWR), 32'h0); chk(rd & 32'h3, 32'h3);
    ahb(1'b1, 32'(OFS_CMD), 32'h1);
    repeat (3) @(posedge clk_sys);
    b(ana.pa_on, 1'b0);
    wt(0);
    chk({ana.rx_bandgap_on, ana.rx_analog_on, ana.rx_ref_clock_on}, 32'h7);
    ahb(1'b0, 32'(OFS_PWR), 32'h0); chk(rd & 32'h3, 32'h2);
    ahb(1'b1, 32'(OFS_CMD), 32'h2);
    repeat (3) @(posedge clk_sys);
    b(ana.rx_analog_on, 1'b0);
    $display("command test done");
    ahb(1'b1, 32'(OFS_PWR), 32'h4);
    ahb(1'b0, 32'(OFS_PWR), 32'h0); chk(rd & 32'h3, 32'h0);
    b(synth_enable, 1'b0);
    ahb(1'b1, 32'(OFS_CMD), 32'h6);
    wt(2);
    rd = 32'h0;
    repeat (60) if (rd[9] !== 1'b1) ahb(1'b0, 32'(OFS_STAT), 32'h0);
    chk({ana.pa_on, op_ready, rd[9]}, 32'h1);
    ahb(1'b1, 32'(OFS_CMD), 32'h8);
    repeat (3) @(posedge clk_sys);
    b(ana.pa_on, 1'b1);
    ahb(1'b1, 32'(OFS_CMD), 32'h10);
    ahb(1'b0, 32'(OFS_PWR), 32'h0); chk(rd & 32'h3, 32'h1);
    b(transmit_enable, 1'b0);
    $display("hold and calibration test done");
    ahb(1'b1, 32'(OFS_IEN), 32'h22);
    @(posedge clk_sys);
    watchdog_expired <= 1'b1;
    @(posedge clk_sys);
    watchdog_expired <= 1'b0;
    ahb(1'b0, 32'(OFS_PWR), 32'h0); chk(rd, 32'h4);
    ahb(1'b1, 32'(OFS_T1), 32'h1);
    ahb(1'b1, 32'(OFS_PWR), 32'h1);
    repeat (20) @(posedge clk_sys);
    b(ana.dig_reg_on, 1'b0);
    ahb(1'b1, 32'(OFS_T1), 32'h0);
    wt(1);
    ahb(1'b0, 32'(OFS_IFL), 32'h0); chk(rd, 32'h22);
    ahb(1'b1, 32'(OFS_PWR), 32'hB);
    ahb(1'b0, 32'(OFS_PWR), 32'h0); chk(rd, 32'hC);
    @(posedge clk_sys);
    serial_select_line <= 1'b1;
    @(posedge clk_sys);
    serial_select_line <= 1'b0;
    ahb(1'b0, 32'(OFS_PWR), 32'h0); chk(rd, 32'h4);
    ahb(1'b0, 32'h100 | (32'($random(seed)) & 32'hFC), 32'h0); chk(rd, 32'h0);
    b(hresp, 1'b0);
    $display("reset and regulator test done");
    test_done;
  end
endmodule
